// ===== verilog/cdoa_params.svh
// Purpose: Constants of the converted data output and alarm block
// Assumes: 40 MHz pclk, byte addresses on APB
// Notes:   Offsets, field codes, character codes and rates
`ifndef CDOA_PARAMS_SVH
`define CDOA_PARAMS_SVH
// ----------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------
`define CDOA_OFF_FORMAT 8'h00
`define CDOA_OFF_BAUD 8'h04
`define CDOA_OFF_AVG 8'h08
`define CDOA_OFF_ALARMS 8'h0C
`define CDOA_OFF_PENABLE 8'h10
`define CDOA_OFF_PLOW 8'h14
`define CDOA_OFF_HTHR 8'h18
`define CDOA_OFF_HHYST 8'h1C
`define CDOA_OFF_CTRL 8'h20
`define CDOA_OFF_STATUS 8'h24
// ----------------------------------------------------------
// Reset values and field codes
// ----------------------------------------------------------
`define CDOA_VAL_W 20
`define CDOA_RST_FORMAT 8'h1F
`define CDOA_RST_BAUD 3'h5
`define CDOA_RST_AVG 16'h0018
`define CDOA_FMT_HGT 8'h81
`define CDOA_FMT_DEP 8'h82
`define CDOA_FMT_DEPHGT 8'h83
`define CDOA_FMT_PRS 8'h90
`define CDOA_FMT_PRSHGT 8'h91
`define CDOA_BOTTOM_BIT 0
`define CDOA_BAUD_MAXCODE 3'h6
// ----------------------------------------------------------
// Averaging limit and rates
// ----------------------------------------------------------
`define CDOA_AVG_K 24
`define CDOA_BITS_COMPACT 40
`define CDOA_BITS_PER_QTY 100
`define CDOA_BAUD0 300
`define CDOA_BAUD1 600
`define CDOA_BAUD2 1200
`define CDOA_BAUD3 2400
`define CDOA_BAUD4 4800
`define CDOA_BAUD5 9600
`define CDOA_BAUD6 19200
`define CDOA_ROUND_HALF 5
// ----------------------------------------------------------
// Characters
// ----------------------------------------------------------
`define CDOA_CH_A 8'h41
`define CDOA_CH_CR 8'h0D
`define CDOA_CH_LF 8'h0A
`define CDOA_CH_SP 8'h20
`define CDOA_CH_DOT 8'h2E
`define CDOA_CH_ZERO 8'h30
`endif

// ===== verilog/cdoa_pkg.sv
// Purpose: Types of the converted data output and alarm block
// Assumes: cdoa_params.svh
// Notes:   Quantity index 0..6 = press, depth, height, temp, cond, sal, sv
`include "cdoa_params.svh"
package cdoa_pkg;
  typedef struct packed {
    logic [7:0] modulo;
    logic [6:0][`CDOA_VAL_W-1:0] q;
  } cdoa_scan_t;
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_NEXT = 6'b000010,
    ST_DIV  = 6'b000100,
    ST_DIG  = 6'b001000,
    ST_TX   = 6'b010000,
    ST_TAIL = 6'b100000
  } cdoa_state_t;
endpackage

// ===== verilog/cdoa_top.sv
// Purpose: Averaged ASCII output of scan values with three alarms
// Assumes: scan values arrive scaled, on pclk, one pulse per scan
// Notes:   Registers over APB, one wait state per access
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module cdoa_top
  import cdoa_pkg::*;
#(
  parameter int CLK_HZ = 40_000_000,
  parameter int AVG_W = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Scan stream
  input wire logic scan_valid,
  input wire cdoa_scan_t scan_in,
  // Converted output port
  input wire logic cop_rxd,
  output logic cop_txd,
  // Remote alarm
  output logic alarm_out
);
  localparam int VW = `CDOA_VAL_W;
  localparam int SW = VW + AVG_W;

  // ----------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------
  function automatic int baud_of(input logic [2:0] b);
    case (b)
      3'h0: return `CDOA_BAUD0;
      3'h1: return `CDOA_BAUD1;
      3'h2: return `CDOA_BAUD2;
      3'h3: return `CDOA_BAUD3;
      3'h4: return `CDOA_BAUD4;
      3'h6: return `CDOA_BAUD6;
      default: return `CDOA_BAUD5;
    endcase
  endfunction

  function automatic logic [AVG_W-1:0] min_avg(input logic [7:0] f, input logic [2:0] b);
    int nb;
    int bd;
    nb = f[7] ? `CDOA_BITS_COMPACT : `CDOA_BITS_PER_QTY * $countones(f[6:0]);
    bd = baud_of(b);
    return AVG_W'((`CDOA_AVG_K * nb + bd - 1) / bd + 1);
  endfunction

  function automatic logic fmt_ok(input logic [7:0] v);
    return !v[7] || v == `CDOA_FMT_HGT || v == `CDOA_FMT_DEP || v == `CDOA_FMT_DEPHGT ||
      v == `CDOA_FMT_PRS || v == `CDOA_FMT_PRSHGT;
  endfunction

  function automatic logic [VW-1:0] pow10(input logic [2:0] i);
    case (i)
      3'h0: return 20'h0_2710;
      3'h1: return 20'h0_03E8;
      3'h2: return 20'h0_0064;
      3'h3: return 20'h0_000A;
      default: return 20'h0_0001;
    endcase
  endfunction

  function automatic logic [VW-1:0] cap_of(input logic [2:0] i);
    case (i)
      3'h0: return 20'h1_869F;
      3'h1: return 20'h0_270F;
      default: return 20'h0_03E7;
    endcase
  endfunction

  // ----------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------
  logic [7:0] fsel_reg;
  logic [2:0] baud_reg;
  logic [AVG_W-1:0] avg_reg;
  logic [2:0] alm_en_reg;
  logic [VW-1:0] pen_reg;
  logic [VW-1:0] plow_reg;
  logic [VW-1:0] hthr_reg;
  logic [VW-1:0] hyst_reg;
  logic stream_reg;
  logic [2:0] alm_reg;
  logic rx_cr;
  logic tx_busy;
  cdoa_state_t st_reg;
  logic [AVG_W-1:0] avg_min;
  logic [19:0] bit_div;
  logic compact;
  logic wr_en;
  logic acc_ph;
  logic mapped;
  logic [31:0] rdata;

  assign compact = fsel_reg[7];
  assign avg_min = min_avg(fsel_reg, baud_reg);
  assign bit_div = 20'(CLK_HZ / baud_of(baud_reg));
  assign acc_ph = psel & penable & ~pready;
  assign wr_en = psel & penable & pready & pwrite;

  always_comb begin
    mapped = (paddr[1:0] == 2'h0) && (paddr <= `CDOA_OFF_STATUS);
    rdata = 32'h0000_0000;
    case (paddr)
      `CDOA_OFF_FORMAT: rdata[7:0] = fsel_reg;
      `CDOA_OFF_BAUD: rdata[2:0] = baud_reg;
      `CDOA_OFF_AVG: rdata[AVG_W-1:0] = avg_reg;
      `CDOA_OFF_ALARMS: rdata[2:0] = alm_en_reg;
      `CDOA_OFF_PENABLE: rdata[VW-1:0] = pen_reg;
      `CDOA_OFF_PLOW: rdata[VW-1:0] = plow_reg;
      `CDOA_OFF_HTHR: rdata[VW-1:0] = hthr_reg;
      `CDOA_OFF_HHYST: rdata[VW-1:0] = hyst_reg;
      `CDOA_OFF_CTRL: rdata[0] = stream_reg;
      `CDOA_OFF_STATUS: rdata[5:0] = {~st_reg[0], tx_busy, stream_reg, alm_reg};
      default: rdata = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------
  // APB answer: one wait state
  // ----------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= acc_ph;
      pslverr <= acc_ph & ~mapped;
      prdata <= (acc_ph & ~pwrite) ? rdata : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fsel_reg <= `CDOA_RST_FORMAT;
      baud_reg <= `CDOA_RST_BAUD;
      avg_reg <= `CDOA_RST_AVG;
      alm_en_reg <= 3'h0;
      pen_reg <= 20'h0_0000;
      plow_reg <= 20'h0_0000;
      hthr_reg <= 20'h0_0000;
      hyst_reg <= 20'h0_0000;
    end else begin
      if (wr_en && paddr == `CDOA_OFF_AVG) begin
        avg_reg <= (pwdata[AVG_W-1:0] < avg_min) ? avg_min : pwdata[AVG_W-1:0];
      end else if (avg_reg < avg_min) begin
        avg_reg <= avg_min;
      end
      if (wr_en) begin
        case (paddr)
          `CDOA_OFF_FORMAT: if (pwdata[31:8] == 24'h00_0000 && fmt_ok(pwdata[7:0])) fsel_reg <= pwdata[7:0];
          `CDOA_OFF_BAUD: if (pwdata[2:0] <= `CDOA_BAUD_MAXCODE) baud_reg <= pwdata[2:0];
          `CDOA_OFF_ALARMS: alm_en_reg <= pwdata[2:0];
          `CDOA_OFF_PENABLE: pen_reg <= pwdata[VW-1:0];
          `CDOA_OFF_PLOW: plow_reg <= pwdata[VW-1:0];
          `CDOA_OFF_HTHR: hthr_reg <= pwdata[VW-1:0];
          `CDOA_OFF_HHYST: hyst_reg <= pwdata[VW-1:0];
          default: ;
        endcase
      end
    end
  end

  // Run command starts streaming unless the format is compact; Enter stops it, a run in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stream_reg <= 1'b1;
    end else if (wr_en && paddr == `CDOA_OFF_CTRL && pwdata[0] && !compact) begin
      stream_reg <= 1'b1;
    end else if (rx_cr) begin
      stream_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------
  // Alarms
  // ----------------------------------------------------------
  logic armed;
  logic [VW:0] alt_clr;
  assign armed = scan_in.q[0] > pen_reg;
  assign alt_clr = {1'b0, hthr_reg} + {1'b0, hyst_reg};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alm_reg <= 3'h0;
      alarm_out <= 1'b0;
    end else begin
      alarm_out <= |(alm_reg & alm_en_reg);
      if (scan_valid) begin
        alm_reg[0] <= scan_in.modulo[`CDOA_BOTTOM_BIT] & armed;
        alm_reg[1] <= (scan_in.q[0] < plow_reg) & armed;
        if ({1'b0, scan_in.q[2]} > alt_clr) begin
          alm_reg[2] <= 1'b0;
        end else if (scan_in.q[2] < hthr_reg && armed) begin
          alm_reg[2] <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------
  // Averaging
  // ----------------------------------------------------------
  logic [AVG_W-1:0] cnt_reg;
  logic [SW-1:0] acc [7];
  logic [SW-1:0] snap [7];
  logic per_end;
  logic seq_idle;
  logic rec_go;
  assign seq_idle = st_reg == ST_IDLE;
  assign per_end = scan_valid && (cnt_reg + 1'b1 >= avg_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
      rec_go <= 1'b0;
    end else begin
      rec_go <= per_end & seq_idle & (compact | stream_reg);
      if (per_end) cnt_reg <= '0;
      else if (scan_valid) cnt_reg <= cnt_reg + 1'b1;
    end
  end

  for (genvar i = 0; i < 7; i++) begin : g_avg
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        acc[i] <= '0;
        snap[i] <= '0;
      end else if (scan_valid) begin
        acc[i] <= per_end ? '0 : acc[i] + SW'(scan_in.q[i]);
        if (per_end && seq_idle) snap[i] <= acc[i] + SW'(scan_in.q[i]);
      end
    end
  end

  // ----------------------------------------------------------
  // Record sequencer
  // ----------------------------------------------------------
  logic [6:0] rem_mask;
  logic [2:0] nxt_f;
  logic [SW-1:0] dv_q;
  logic [AVG_W:0] dv_r;
  logic [AVG_W:0] r_sh;
  logic [5:0] dv_n;
  logic [SW:0] dv_v;
  logic [VW-1:0] val;
  logic [VW-1:0] capv;
  logic [2:0] pi;
  logic [2:0] pend;
  logic [2:0] dotpos;
  logic [3:0] dig;
  logic dot_pend;
  logic lead_sp;
  logic [1:0] spc;
  logic [1:0] tcnt;
  logic in_tail;
  logic tog;
  logic [7:0] tx_char;
  logic tx_start;
  logic combo;
  logic show_h;
  logic [2:0] cmp_f;
  logic [2:0] cmp_pi;

  assign r_sh = {dv_r[AVG_W-1:0], dv_q[SW-1]};
  assign dv_v = {1'b0, dv_q} + (compact ? (SW+1)'(`CDOA_ROUND_HALF) : '0);
  assign capv = cap_of(pi);
  assign combo = fsel_reg[0] & (fsel_reg[1] | fsel_reg[4]);
  // First combined record shows height, then the other quantity
  assign show_h = combo ? ~tog : fsel_reg[0];
  assign cmp_f = show_h ? 3'h2 : (fsel_reg[4] ? 3'h0 : 3'h1);
  // Compact: four integer digits, three for height when combined
  assign cmp_pi = (combo && nxt_f == 3'h2) ? 3'h1 : 3'h0;

  always_comb begin
    nxt_f = 3'h0;
    for (int k = 6; k >= 0; k--) begin
      if (rem_mask[k]) nxt_f = 3'(k);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= ST_IDLE;
      rem_mask <= 7'h00;
      dv_q <= '0;
      dv_r <= '0;
      dv_n <= 6'h00;
      val <= '0;
      pi <= 3'h0;
      pend <= 3'h0;
      dotpos <= 3'h0;
      dig <= 4'h0;
      dot_pend <= 1'b0;
      lead_sp <= 1'b0;
      spc <= 2'h0;
      tcnt <= 2'h0;
      in_tail <= 1'b0;
      tog <= 1'b0;
      tx_char <= 8'h00;
      tx_start <= 1'b0;
    end else begin
      tx_start <= 1'b0;
      case (st_reg)
        ST_IDLE: begin
          if (rec_go) begin
            if (compact) begin
              rem_mask <= 7'h01 << cmp_f;
              tog <= combo & ~tog;
            end else begin
              rem_mask <= {fsel_reg[6], fsel_reg[5], fsel_reg[3], fsel_reg[2],
                fsel_reg[0], fsel_reg[1], fsel_reg[4]};
            end
            tcnt <= 2'h0;
            in_tail <= 1'b0;
            st_reg <= ST_NEXT;
          end
        end
        ST_NEXT: begin
          if (rem_mask == 7'h00) begin
            in_tail <= ~compact;
            st_reg <= compact ? ST_IDLE : ST_TAIL;
          end else begin
            rem_mask[nxt_f] <= 1'b0;
            dv_q <= snap[nxt_f];
            dv_r <= '0;
            dv_n <= 6'(SW);
            pi <= compact ? cmp_pi : (nxt_f == 3'h4 ? 3'h1 : 3'h0);
            pend <= compact ? 3'h3 : 3'h4;
            dotpos <= (nxt_f >= 3'h3 && nxt_f <= 3'h5) ? 3'h1 : 3'h3;
            lead_sp <= compact && cmp_pi == 3'h1;
            spc <= 2'h0;
            dig <= 4'h0;
            dot_pend <= 1'b0;
            st_reg <= ST_DIV;
          end
        end
        ST_DIV: begin
          if (dv_n == 6'h00) begin
            val <= (dv_v > {{(SW+1-VW){1'b0}}, capv}) ? capv : dv_v[VW-1:0];
            st_reg <= ST_DIG;
          end else begin
            dv_n <= dv_n - 6'h01;
            if (r_sh >= {1'b0, avg_reg}) begin
              dv_r <= r_sh - {1'b0, avg_reg};
              dv_q <= {dv_q[SW-2:0], 1'b1};
            end else begin
              dv_r <= r_sh;
              dv_q <= {dv_q[SW-2:0], 1'b0};
            end
          end
        end
        ST_DIG: begin
          if (lead_sp) begin
            lead_sp <= 1'b0;
            tx_char <= `CDOA_CH_SP;
            st_reg <= ST_TX;
          end else if (dot_pend) begin
            dot_pend <= 1'b0;
            tx_char <= `CDOA_CH_DOT;
            st_reg <= ST_TX;
          end else if (pi <= pend) begin
            if (val >= pow10(pi)) begin
              val <= val - pow10(pi);
              dig <= dig + 4'h1;
            end else begin
              tx_char <= `CDOA_CH_ZERO + {4'h0, dig};
              dig <= 4'h0;
              dot_pend <= !compact && pi == dotpos;
              pi <= pi + 3'h1;
              st_reg <= ST_TX;
            end
          end else if (compact) begin
            st_reg <= ST_IDLE;
          end else if (spc != 2'h2) begin
            spc <= spc + 2'h1;
            tx_char <= `CDOA_CH_SP;
            st_reg <= ST_TX;
          end else begin
            st_reg <= ST_NEXT;
          end
        end
        ST_TX: begin
          if (!tx_busy) begin
            tx_start <= 1'b1;
            st_reg <= in_tail ? ST_TAIL : ST_DIG;
          end
        end
        ST_TAIL: begin
          tcnt <= tcnt + 2'h1;
          case (tcnt)
            2'h0: begin
              tx_char <= `CDOA_CH_A;
              if (alarm_out) st_reg <= ST_TX;
            end
            2'h1: begin
              tx_char <= `CDOA_CH_CR;
              st_reg <= ST_TX;
            end
            2'h2: begin
              tx_char <= `CDOA_CH_LF;
              st_reg <= ST_TX;
            end
            default: st_reg <= ST_IDLE;
          endcase
        end
        default: st_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------
  // Serial transmitter, 8N1
  // ----------------------------------------------------------
  logic [19:0] tx_cnt;
  logic [8:0] tx_sh;
  logic [3:0] tx_n;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cop_txd <= 1'b1;
      tx_busy <= 1'b0;
      tx_cnt <= 20'h0_0000;
      tx_sh <= 9'h1FF;
      tx_n <= 4'h0;
    end else if (tx_start) begin
      cop_txd <= 1'b0;
      tx_sh <= {1'b1, tx_char};
      tx_n <= 4'h9;
      tx_cnt <= bit_div - 20'h0_0001;
      tx_busy <= 1'b1;
    end else if (tx_busy) begin
      if (tx_cnt != 20'h0_0000) begin
        tx_cnt <= tx_cnt - 20'h0_0001;
      end else if (tx_n == 4'h0) begin
        tx_busy <= 1'b0;
      end else begin
        cop_txd <= tx_sh[0];
        tx_sh <= {1'b1, tx_sh[8:1]};
        tx_n <= tx_n - 4'h1;
        tx_cnt <= bit_div - 20'h0_0001;
      end
    end
  end

  // ----------------------------------------------------------
  // Serial receiver: watches for Enter
  // ----------------------------------------------------------
  logic rx_m;
  logic rx_s;
  logic rx_act;
  logic [19:0] rx_cnt;
  logic [3:0] rx_n;
  logic [7:0] rx_sh;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_m <= 1'b1;
      rx_s <= 1'b1;
    end else begin
      rx_m <= cop_rxd;
      rx_s <= rx_m;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_act <= 1'b0;
      rx_cnt <= 20'h0_0000;
      rx_n <= 4'h0;
      rx_sh <= 8'h00;
      rx_cr <= 1'b0;
    end else begin
      rx_cr <= 1'b0;
      if (!rx_act) begin
        if (!rx_s) begin
          rx_act <= 1'b1;
          rx_cnt <= {1'b0, bit_div[19:1]};
          rx_n <= 4'h0;
        end
      end else if (rx_cnt != 20'h0_0000) begin
        rx_cnt <= rx_cnt - 20'h0_0001;
      end else begin
        rx_cnt <= bit_div - 20'h0_0001;
        if (rx_n == 4'h0) begin
          rx_act <= ~rx_s;
          rx_n <= 4'h1;
        end else if (rx_n != 4'h9) begin
          rx_sh <= {rx_s, rx_sh[7:1]};
          rx_n <= rx_n + 4'h1;
        end else begin
          rx_act <= 1'b0;
          rx_cr <= rx_s && rx_sh == `CDOA_CH_CR;
        end
      end
    end
  end

endmodule // cdoa_top
`default_nettype wire

// ===== verification/cdoa_checker.sv
// Purpose: Port assertions for cdoa_top
// Assumes: APB byte map, at least five pclk per serial bit
// Notes:   Alarm mask is shadowed from APB writes
`timescale 1ns/1ps
`default_nettype none
module cdoa_checker
  import cdoa_pkg::*;
#(
  parameter int CLK_HZ = 40_000_000
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Scans, serial and alarm
  input wire logic scan_valid,
  input wire cdoa_scan_t scan_in,
  input wire logic cop_rxd,
  input wire logic cop_txd,
  input wire logic alarm_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [2:0] mask_reg;
  wire logic done = psel && penable && pready && !pslverr;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= 3'h0;
    end else if (done && pwrite && paddr == 8'h0C) begin
      mask_reg <= pwdata[2:0];
    end
  end
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_low5;
    !cop_txd [*5];
  endsequence
  chk_ready_one: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  chk_ready_access: assert property (pready |-> s_access) else $error("pready outside access phase");
  chk_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000) else $error("prdata not zero");
  chk_format_valid: assert property (done && !pwrite && paddr == 8'h00 |-> prdata[31:8] == 24'h00_0000 &&
    (!prdata[7] || prdata[7:0] inside {8'h81, 8'h82, 8'h83, 8'h90, 8'h91})) else $error("bad format held");
  chk_scan_average_count_nonzero: assert property (done && !pwrite && paddr == 8'h08 |->
    prdata[15:0] != 16'h0000 && prdata[31:16] == 16'h0000) else $error("averaging count below one");
  chk_alarm_mask: assert property (alarm_out |-> mask_reg != 3'h0 || $past(mask_reg) != 3'h0)
    else $error("alarm with all alarms disabled");
  chk_alarm_cause: assert property ($rose(alarm_out) |-> $past(scan_valid) || $past(scan_valid, 2) ||
    $past(pready) || $past(pready, 2)) else $error("alarm rose without cause");
  chk_start_bit: assert property ($fell(cop_txd) |-> s_low5) else $error("start bit too short");
endmodule // cdoa_checker
bind cdoa_top cdoa_checker #(.CLK_HZ(CLK_HZ)) cdoa_checker_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .scan_valid(scan_valid), .scan_in(scan_in), .cop_rxd(cop_rxd), .cop_txd(cop_txd),
  .alarm_out(alarm_out));
`default_nettype wire

// ===== verification/cdoa_host_model.sv
// Purpose: Remote host on the converted output port
// Assumes: 8N1 at a fixed bit time in pclk cycles
// Notes:   Received characters collect in q
`timescale 1ns/1ps
`default_nettype none
module cdoa_host_model #(
  parameter int BIT = 10
) (
  // Clock
  input wire logic pclk,
  // Serial lines
  input wire logic txd,
  output logic rxd
);
  logic [7:0] q[$];
  logic [7:0] b;
  initial rxd = 1'b1;
  // Receiver sampling mid bit, LSB first
  initial begin
    forever begin
      @(posedge pclk);
      if (txd === 1'b0) begin
        repeat (BIT / 2) @(posedge pclk);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT) @(posedge pclk);
          b[i] = txd;
        end
        repeat (BIT) @(posedge pclk);
        q.push_back(b);
      end
    end
  end
  // One keystroke, start bit first
  task send(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge pclk);
      rxd <= f[i];
      repeat (BIT - 1) @(posedge pclk);
    end
  endtask
endmodule // cdoa_host_model
`default_nettype wire

// ===== verification/cdoa_tb.sv
// Purpose: Self-checking bench of cdoa_top
// Assumes: CLK_HZ scaled so a bit is ten pclk at 9600
// Notes:   Every scan carries the same pressure and depth
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, x, g) begin check_count++; if ((g) !== (x)) begin n_fail++; $display("MISMATCH %s exp %0h got %0h", nm, x, g); end end
module tb
  import cdoa_pkg::*;
;
  localparam int CLK_HZ = 96_000;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, scan_valid, cop_rxd, cop_txd, alarm_out, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  cdoa_scan_t scan_in;
  int n_fail, check_count, cyc;
  cdoa_top #(.CLK_HZ(CLK_HZ)) cdoa_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scan_valid(scan_valid), .scan_in(scan_in), .cop_rxd(cop_rxd), .cop_txd(cop_txd), .alarm_out(alarm_out));
  cdoa_host_model #(.BIT(CLK_HZ / 9600)) cdoa_host_model_i (.pclk(pclk), .txd(cop_txd), .rxd(cop_rxd));
  // ----------------------------------------------------------
  // Bus and stream drivers
  // ----------------------------------------------------------
  task rw(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x, input string nm);
    rw(1'b0, a, 32'h0000_0000);
    `CHK(nm, x, r)
  endtask
  task scan(input logic [19:0] h, input logic m);
    cdoa_scan_t s;
    s = '0;
    s.modulo = {7'h00, m};
    s.q[0] = 20'h0_3039;
    s.q[1] = 20'h0_02A6;
    s.q[2] = h;
    @(posedge pclk);
    scan_valid <= 1'b1;
    scan_in <= s;
    @(posedge pclk);
    scan_valid <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  // Waits until no record is being sent, then expects one record
  task rec(input string x);
    int n;
    n = 0;
    do begin
      rw(1'b0, 8'h24, 32'h0000_0000);
      n++;
    end while (r[5:4] !== 2'b00 && n < 2000);
    cdoa_host_model_i.q.delete();
    scan(20'h0_0064, 1'b0);
    scan(20'h0_0064, 1'b0);
    n = 0;
    while (cdoa_host_model_i.q.size() < x.len() && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    for (int i = 0; i < x.len(); i++) `CHK("record", x[i], cdoa_host_model_i.q[i])
  endtask
  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task t_reset;
    rd(8'h00, 8'h1F, "format");
    rd(8'h04, 8'h05, "baud");
    rd(8'h08, 8'h18, "avg_count");
    rd(8'h0C, 8'h00, "alarms");
    rw(1'b0, 8'h28, 32'h0000_0000);
    `CHK("unmapped", 1'b1, e)
  endtask
  task t_format;
    logic [7:0] c[5];
    c = '{8'h81, 8'h82, 8'h83, 8'h90, 8'h91};
    for (int i = 0; i < 5; i++) begin
      rw(1'b1, 8'h00, {24'h00_0000, c[i]});
      rd(8'h00, c[i], "format");
    end
    rw(1'b1, 8'h00, 32'h0000_0080);
    rd(8'h00, 8'h91, "format");
    rw(1'b1, 8'h00, 32'h0000_0084);
    rd(8'h00, 8'h91, "format");
  endtask
  task t_scan_average_count;
    rw(1'b1, 8'h04, 32'h0000_0000);
    rw(1'b1, 8'h08, 32'h0000_0001);
    rd(8'h08, 8'h05, "avg_count");
    rw(1'b1, 8'h00, 32'h0000_007F);
    rd(8'h08, 8'h39, "avg_count");
    rw(1'b1, 8'h04, 32'h0000_0007);
    rd(8'h04, 8'h00, "baud");
    for (int b = 1; b < 7; b++) begin
      rw(1'b1, 8'h04, b);
      rd(8'h04, b, "baud");
    end
    rw(1'b1, 8'h04, 32'h0000_0005);
    rw(1'b1, 8'h00, 32'h0000_0012);
    rw(1'b1, 8'h08, 32'h0000_0001);
    rd(8'h08, 8'h02, "avg_count");
  endtask
  task t_alarm;
    rw(1'b1, 8'h10, 32'h0000_0064);
    rw(1'b1, 8'h14, 32'h0000_4E20);
    rw(1'b1, 8'h18, 32'h0000_01F4);
    rw(1'b1, 8'h1C, 32'h0000_0064);
    scan(20'h0_0190, 1'b1);
    `CHK("alarm_out", 1'b0, alarm_out)
    rw(1'b0, 8'h24, 32'h0000_0000);
    `CHK("raw", 3'h7, r[2:0])
    rw(1'b1, 8'h0C, 32'h0000_0004);
    repeat (3) @(posedge pclk);
    `CHK("alarm_out", 1'b1, alarm_out)
    scan(20'h0_0226, 1'b0);
    `CHK("alarm_out", 1'b1, alarm_out)
    scan(20'h0_028A, 1'b0);
    `CHK("alarm_out", 1'b0, alarm_out)
    rw(1'b1, 8'h0C, 32'h0000_0001);
    repeat (3) @(posedge pclk);
    `CHK("alarm_out", 1'b0, alarm_out)
    rw(1'b1, 8'h0C, 32'h0000_0002);
    repeat (3) @(posedge pclk);
    `CHK("alarm_out", 1'b1, alarm_out)
  endtask
  task t_record;
    rec("1234.5  0067.8  A\r\n");
    rw(1'b1, 8'h0C, 32'h0000_0000);
    rec("1234.5  0067.8  \r\n");
  endtask
  task t_stop;
    cdoa_host_model_i.send(8'h0D);
    repeat (20) @(posedge pclk);
    rd(8'h20, 8'h00, "ctrl");
    rw(1'b1, 8'h00, 32'h0000_0081);
    rw(1'b1, 8'h20, 32'h0000_0001);
    rd(8'h20, 8'h00, "ctrl");
    rec("0010");
    rw(1'b1, 8'h00, 32'h0000_0091);
    rec(" 010");
    rec("1235");
    rw(1'b1, 8'h00, 32'h0000_0012);
    rw(1'b1, 8'h20, 32'h0000_0001);
    rd(8'h20, 8'h01, "ctrl");
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      tally_and_finish;
    end
  end
  initial begin
    {psel, penable, pwrite, scan_valid, presetn} = 5'h00;
    {paddr, pwdata, scan_in} = '0;
    {n_fail, check_count, cyc} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_format;
    t_scan_average_count;
    t_alarm;
    t_record;
    t_stop;
    tally_and_finish;
  end
endmodule // tb
`default_nettype wire
